// [tb_top.sv]
// Self-checking bench for the timer match / prescale register slave.
// Assumes tmp_pkg and tmp_defines.svh come first; the bench drives every port.
`include "tmp_defines.svh"
`default_nettype none
module tb_top
   import tmp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite;     // Clock, reset, APB control
   logic        cfg_32bit, cfg_rtc;                       // Pair configuration
   logic [11:0] paddr;                                    // Byte address
   logic [31:0] pwdata, prdata, count_a, match_a, rd_d;   // Bus and counter words
   logic        pready, pslverr, rtc_match, rd_e;         // Answer and match flags
   logic        match_a_hit, match_b_hit;                 // 24-bit match flags
   logic [15:0] count_b, stamp_a, stamp_b, load_a;        // Counter side inputs
   logic [15:0] load_b, match_b, span_a, span_b;          // Active values out
   logic [7:0]  pre_cnt_a, pre_cnt_b, pre_a, pre_b;       // Prescale counts and fields
   logic [7:0]  pmatch_a, pmatch_b;                       // Prescale-match fields
   tmp_mode_t   mode_a, mode_b;                           // Per-timer modes
   int          fail_count, n_checks;                     // Report counters
   int          cycles = 0;                               // Timeout counter
   logic [11:0] offs [4];                                 // Prescale register table
   logic [7:0]  vals [4];                                 // Values written there

   tmp_regs i_tmp_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cfg_32bit(cfg_32bit), .cfg_rtc(cfg_rtc),
      .mode_a(mode_a), .mode_b(mode_b), .count_a(count_a), .count_b(count_b),
      .pre_cnt_a(pre_cnt_a), .pre_cnt_b(pre_cnt_b), .stamp_a(stamp_a), .stamp_b(stamp_b),
      .load_a(load_a), .load_b(load_b), .match_a(match_a), .match_b(match_b),
      .pre_a(pre_a), .pre_b(pre_b), .pmatch_a(pmatch_a), .pmatch_b(pmatch_b),
      .rtc_match(rtc_match), .match_a_hit(match_a_hit), .match_b_hit(match_b_hit),
      .span_a(span_a), .span_b(span_b)
   );

   // Free-running 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Hang guard, well above the length of the sequence
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end

   // One comparison, four-state exact
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No wait-state limit here: only the hang guard ends a stuck wait
      while (pready !== 1'b1) begin
         n++;
         @(posedge pclk);
      end
      chk("wait states", 32'h0000_0000, 32'(n));
      rd_d = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Read and compare data
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), exp, rd_d);
   endtask : rd

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Let registered outputs settle after an input change
   task wt;
      repeat (2) @(posedge pclk);
      #1;
   endtask : wt

   // Reset held 8 cycles; first request two edges after release
   task rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst

   task results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      {psel, penable, pwrite, presetn, cfg_32bit, cfg_rtc} = 6'h00;
      {paddr, pwdata, count_a, count_b, stamp_a, stamp_b, load_a} = 140'h0;
      {pre_cnt_a, pre_cnt_b} = 16'h0000;
      mode_a = TMP_MODE_PERIODIC;
      mode_b = TMP_MODE_PERIODIC;
      fail_count = 0;
      n_checks = 0;
      offs = '{`TMP_OFF_A_PRE, `TMP_OFF_B_PRE, `TMP_OFF_A_PMATCH, `TMP_OFF_B_PMATCH};
      vals = '{8'h5A, 8'hC3, 8'h12, 8'h34};
      rst();
      // Reset values in 16-bit configuration
      rd(`TMP_OFF_B_LOAD, 32'h0000_FFFF);
      rd(`TMP_OFF_A_MATCH, 32'h0000_FFFF);
      rd(`TMP_OFF_B_MATCH, 32'h0000_FFFF);
      chk("pslverr", 32'h0, {31'h0, rd_e});
      // Prescale and prescale-match fields reset to zero and read back
      for (int i = 0; i < 4; i++) begin
         rd(offs[i], 32'h0000_0000);
         wr(offs[i], {24'h0, vals[i]});
         rd(offs[i], {24'h0, vals[i]});
      end
      chk("pre", 32'h5AC3_1234, {pre_a, pre_b, pmatch_a, pmatch_b});
      // Timer B load writable outside 32-bit configuration
      wr(`TMP_OFF_B_LOAD, 32'h0000_1234);
      rd(`TMP_OFF_B_LOAD, 32'h0000_1234);
      // Match high half refused in 16-bit, B match untouched
      wr(`TMP_OFF_A_MATCH, 32'hABCD_0100);
      rd(`TMP_OFF_A_MATCH, 32'h0000_0100);
      chk("match_b", 32'h0000_FFFF, {16'h0, match_b});
      chk("match_a", 32'h0000_0100, match_a);
      wr(`TMP_OFF_B_MATCH, 32'h0000_0200);
      // Duty and edge spans are load minus match
      @(posedge pclk);
      load_a <= 16'h0500;
      mode_a <= TMP_MODE_PWM;
      mode_b <= TMP_MODE_PWM;
      wt();
      chk("span", 32'h0400_1034, {span_a, span_b});
      // 24-bit match uses prescale match above the 16-bit match
      @(posedge pclk);
      count_a   <= 32'h0000_0100;
      count_b   <= 16'h0200;
      pre_cnt_a <= 8'h12;
      pre_cnt_b <= 8'h34;
      wt();
      chk("hits", 32'h3, {30'h0, match_a_hit, match_b_hit});
      @(posedge pclk);
      pre_cnt_a <= 8'h13;
      wt();
      chk("hit_a", 32'h0, {31'h0, match_a_hit});
      // Value registers: count, then edge timestamp; high half zero in 16-bit
      @(posedge pclk);
      count_a <= 32'h2222_1111;
      count_b <= 16'h2222;
      stamp_a <= 16'h3333;
      stamp_b <= 16'h4444;
      rd(`TMP_OFF_A_VALUE, 32'h0000_1111);
      rd(`TMP_OFF_B_VALUE, 32'h0000_2222);
      @(posedge pclk);
      mode_a <= TMP_MODE_EDGE;
      mode_b <= TMP_MODE_EDGE;
      wr(`TMP_OFF_B_VALUE, 32'h0000_9999);
      rd(`TMP_OFF_A_VALUE, 32'h0000_3333);
      rd(`TMP_OFF_B_VALUE, 32'h0000_4444);
      chk("span_e", 32'h0400_1034, {span_a, span_b});
      // Unmapped and unaligned addresses answer with an error
      rd(12'h050, 32'h0000_0000);
      chk("err 050", 32'h1, {31'h0, rd_e});
      rd(12'h02E, 32'h0000_0000);
      chk("err 02E", 32'h1, {31'h0, rd_e});
      // Second reset in 32-bit RTC configuration
      @(posedge pclk);
      cfg_32bit <= 1'b1;
      cfg_rtc   <= 1'b1;
      mode_a    <= TMP_MODE_PERIODIC;
      mode_b    <= TMP_MODE_PERIODIC;
      rst();
      rd(`TMP_OFF_A_MATCH, 32'hFFFF_FFFF);
      rd(`TMP_OFF_A_VALUE, 32'h2222_1111);
      rd(`TMP_OFF_B_LOAD, 32'h0000_2222);
      wr(`TMP_OFF_B_LOAD, 32'h0000_5555);
      rd(`TMP_OFF_B_LOAD, 32'h0000_2222);
      chk("load_b", 32'h0000_FFFF, {16'h0, load_b});
      // RTC match compares both halves
      wr(`TMP_OFF_A_MATCH, 32'h2222_1111);
      wt();
      chk("match_a32", 32'h2222_1111, match_a);
      chk("rtc", 32'h1, {31'h0, rtc_match});
      @(posedge pclk);
      count_a <= 32'h2222_1112;
      wt();
      chk("rtc lo", 32'h0, {31'h0, rtc_match});
      @(posedge pclk);
      count_a <= 32'h2223_1111;
      count_b <= 16'h2223;
      wt();
      chk("rtc hi", 32'h0, {31'h0, rtc_match});
      results();
   end
endmodule : tb_top
`default_nettype wire

// [tmp_defines.svh]
// Constants for the timer match / prescale register block.
// Assumes the includer wants offsets, address bounds and reset values by name.
`ifndef TMP_DEFINES_SVH
`define TMP_DEFINES_SVH
`define TMP_OFF_B_LOAD     12'h02C
`define TMP_OFF_A_MATCH    12'h030
`define TMP_OFF_B_MATCH    12'h034
`define TMP_OFF_A_PRE      12'h038
`define TMP_OFF_B_PRE      12'h03C
`define TMP_OFF_A_PMATCH   12'h040
`define TMP_OFF_B_PMATCH   12'h044
`define TMP_OFF_A_VALUE    12'h048
`define TMP_OFF_B_VALUE    12'h04C
`define TMP_OFF_LOWER      12'h02C
`define TMP_OFF_UPPER      12'h04C
`define TMP_HALF_ONES      16'hFFFF
`define TMP_HALF_ZERO      16'h0000
`define TMP_BYTE_ZERO      8'h00
`define TMP_WORD_ZERO      32'h0000_0000
`endif

// [tmp_half_timer.sv]
// One timer half: 16-bit match/load view plus 8-bit prescale extension.
// Assumes count and edge timestamps come from counter logic on pclk.
`include "tmp_defines.svh"
`default_nettype none
module tmp_half_timer
   import tmp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pre_we,     // Prescale write strobe
   input  wire logic        pmatch_we,  // Prescale-match write strobe
   input  wire logic [7:0]  wdata,
   input  wire logic [15:0] match_val,  // Active 16-bit match
   input  wire logic [15:0] load_val,   // Active 16-bit load
   input  wire logic [23:0] count24,    // Prescale:count from the counter
   input  wire logic [15:0] stamp,      // Last edge timestamp
   input  wire tmp_mode_t   mode,
   output logic [7:0]       pre_q,
   output logic [7:0]       pmatch_q,
   output logic [15:0]      value,      // What the value register shows
   output logic             match_hit,  // 24-bit match in this cycle
   output logic [15:0]      span        // Load minus match
);
   // Prescale and prescale-match storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q    <= `TMP_BYTE_ZERO;
         pmatch_q <= `TMP_BYTE_ZERO;
      end else begin
         if (pre_we) begin
            pre_q <= wdata;
         end
         if (pmatch_we) begin
            pmatch_q <= wdata;
         end
      end
   end
   // Match spans prescale byte and 16-bit match
   assign match_hit = (count24 == {pmatch_q, match_val});
   // Edge count total; PWM duty uses the same pair
   assign span  = load_val - match_val;
   assign value = (mode == TMP_MODE_EDGE) ? stamp : count24[15:0];
endmodule : tmp_half_timer
`default_nettype wire

// [tmp_pkg.sv]
// Types shared by the timer match / prescale register block.
// Assumes tmp_defines.svh is on the include path.
`default_nettype none
package tmp_pkg;
   // Pair configuration, a small state machine over reset release
   typedef enum logic [1:0] {
      TMP_CFG_WAIT = 2'b00,  // Reset just released, strap not yet caught
      TMP_CFG_LIVE = 2'b01   // Configuration captured
   } tmp_cfg_state_t;
   // Per-timer operating mode, given by the mode logic outside
   typedef enum logic [1:0] {
      TMP_MODE_PERIODIC = 2'b00,
      TMP_MODE_PWM      = 2'b01,
      TMP_MODE_EDGE     = 2'b11
   } tmp_mode_t;
endpackage : tmp_pkg
`default_nettype wire

// [tmp_regs.sv]
// APB register slave for timer B load, match, prescale and value registers.
// Assumes counters, mode select and interval load A live in the mode logic.
`include "tmp_defines.svh"
`default_nettype none
module tmp_regs
   import tmp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cfg_32bit,     // Pair in a 32-bit configuration
   input  wire logic        cfg_rtc,       // 32-bit real-time-clock mode
   input  wire tmp_mode_t   mode_a,
   input  wire tmp_mode_t   mode_b,
   input  wire logic [31:0] count_a,       // Timer A count, 32 bits in pair
   input  wire logic [15:0] count_b,
   input  wire logic [7:0]  pre_cnt_a,     // Prescale counters
   input  wire logic [7:0]  pre_cnt_b,
   input  wire logic [15:0] stamp_a,
   input  wire logic [15:0] stamp_b,
   input  wire logic [15:0] load_a,        // Timer A interval load
   output logic [15:0]      load_b,
   output logic [31:0]      match_a,
   output logic [15:0]      match_b,
   output logic [7:0]       pre_a,
   output logic [7:0]       pre_b,
   output logic [7:0]       pmatch_a,
   output logic [7:0]       pmatch_b,
   output logic             rtc_match,     // 32-bit RTC match
   output logic             match_a_hit,
   output logic             match_b_hit,
   output logic [15:0]      span_a,        // Edges to count / duty span
   output logic [15:0]      span_b
);
   tmp_cfg_state_t   cfg_st_q;       // Strap capture state
   logic             cfg32_rst_q;    // Configuration seen at reset release
   logic [15:0]      load_b_q;
   logic [15:0]      match_al_q;
   logic [15:0]      match_ah_q;
   logic [15:0]      match_b_q;
   logic             wr_en;          // Access-phase write
   logic             rd_en;
   logic             mapped;
   logic [7:0]       pre_a_w;
   logic [7:0]       pre_b_w;
   logic [7:0]       pm_a_w;
   logic [7:0]       pm_b_w;
   logic [15:0]      val_a;
   logic [15:0]      val_b;
   logic             hit_a_w;
   logic             hit_b_w;
   logic [15:0]      span_a_w;
   logic [15:0]      span_b_w;
   logic [31:0]      rd_d;

   // Zero-wait slave: every access completes in its first access cycle
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && !penable && !pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr >= `TMP_OFF_LOWER)
                   && (paddr <= `TMP_OFF_UPPER);

   // Catch the configuration once, the first edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_st_q    <= TMP_CFG_WAIT;
         cfg32_rst_q <= 1'b0;
      end else begin
         case (cfg_st_q)
            TMP_CFG_WAIT: begin
               cfg32_rst_q <= cfg_32bit;
               cfg_st_q    <= TMP_CFG_LIVE;
            end
            TMP_CFG_LIVE: cfg_st_q <= TMP_CFG_LIVE;
            default:      cfg_st_q <= TMP_CFG_WAIT;
         endcase
      end
   end

   // Timer B load, ignored while paired
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_b_q <= `TMP_HALF_ONES;
      end else if (wr_en && paddr == `TMP_OFF_B_LOAD && !cfg_32bit) begin
         load_b_q <= pwdata[15:0];
      end
   end

   // Timer A match; high half cleared after reset in 16-bit pairs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_al_q <= `TMP_HALF_ONES;
         match_ah_q <= `TMP_HALF_ONES;
      end else if (cfg_st_q == TMP_CFG_WAIT && !cfg_32bit) begin
         match_ah_q <= `TMP_HALF_ZERO;
      end else if (wr_en && paddr == `TMP_OFF_A_MATCH) begin
         match_al_q <= pwdata[15:0];
         if (cfg_32bit) begin
            match_ah_q <= pwdata[31:16];
         end
      end
   end

   // Timer B match, never touched by timer A match writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_b_q <= `TMP_HALF_ONES;
      end else if (wr_en && paddr == `TMP_OFF_B_MATCH) begin
         match_b_q <= pwdata[15:0];
      end
   end

   tmp_half_timer u_half_a (
      .pclk      (pclk),
      .presetn   (presetn),
      .pre_we    (wr_en && paddr == `TMP_OFF_A_PRE),
      .pmatch_we (wr_en && paddr == `TMP_OFF_A_PMATCH),
      .wdata     (pwdata[7:0]),
      .match_val (match_al_q),
      .load_val  (load_a),
      .count24   ({pre_cnt_a, count_a[15:0]}),
      .stamp     (stamp_a),
      .mode      (mode_a),
      .pre_q     (pre_a_w),
      .pmatch_q  (pm_a_w),
      .value     (val_a),
      .match_hit (hit_a_w),
      .span      (span_a_w)
   );

   tmp_half_timer u_half_b (
      .pclk      (pclk),
      .presetn   (presetn),
      .pre_we    (wr_en && paddr == `TMP_OFF_B_PRE),
      .pmatch_we (wr_en && paddr == `TMP_OFF_B_PMATCH),
      .wdata     (pwdata[7:0]),
      .match_val (match_b_q),
      .load_val  (load_b_q),
      .count24   ({pre_cnt_b, count_b}),
      .stamp     (stamp_b),
      .mode      (mode_b),
      .pre_q     (pre_b_w),
      .pmatch_q  (pm_b_w),
      .value     (val_b),
      .match_hit (hit_b_w),
      .span      (span_b_w)
   );

   // Read mux; unused upper bits read zero
   always_comb begin
      rd_d = `TMP_WORD_ZERO;
      case (paddr)
         `TMP_OFF_B_LOAD:   rd_d[15:0] = cfg_32bit ? count_b : load_b_q;
         `TMP_OFF_A_MATCH:  rd_d = {(cfg_32bit ? match_ah_q : `TMP_HALF_ZERO),
                                    match_al_q};
         `TMP_OFF_B_MATCH:  rd_d[15:0] = match_b_q;
         `TMP_OFF_A_PRE:    rd_d[7:0]  = pre_a_w;
         `TMP_OFF_B_PRE:    rd_d[7:0]  = pre_b_w;
         `TMP_OFF_A_PMATCH: rd_d[7:0]  = pm_a_w;
         `TMP_OFF_B_PMATCH: rd_d[7:0]  = pm_b_w;
         `TMP_OFF_A_VALUE:  rd_d = {(cfg_32bit ? count_b : `TMP_HALF_ZERO),
                                    val_a};
         `TMP_OFF_B_VALUE:  rd_d[15:0] = val_b;
         default:           rd_d = `TMP_WORD_ZERO;
      endcase
   end

   // Read data registered in setup, valid in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `TMP_WORD_ZERO;
      end else if (rd_en) begin
         prdata <= rd_d;
      end
   end

   // Ready in the first access cycle only; unmapped or unaligned offsets answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Registered views for the counter logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_b      <= `TMP_HALF_ONES;
         match_a     <= {`TMP_HALF_ONES, `TMP_HALF_ONES};
         match_b     <= `TMP_HALF_ONES;
         pre_a       <= `TMP_BYTE_ZERO;
         pre_b       <= `TMP_BYTE_ZERO;
         pmatch_a    <= `TMP_BYTE_ZERO;
         pmatch_b    <= `TMP_BYTE_ZERO;
         rtc_match   <= 1'b0;
         match_a_hit <= 1'b0;
         match_b_hit <= 1'b0;
         span_a      <= `TMP_HALF_ZERO;
         span_b      <= `TMP_HALF_ZERO;
      end else begin
         load_b      <= load_b_q;
         match_a     <= {match_ah_q, match_al_q};
         match_b     <= match_b_q;
         pre_a       <= pre_a_w;
         pre_b       <= pre_b_w;
         pmatch_a    <= pm_a_w;
         pmatch_b    <= pm_b_w;
         // Both halves compared against the 32-bit count
         rtc_match   <= cfg_rtc && (count_a[31:16] == match_ah_q)
                        && (count_a[15:0] == match_al_q);
         match_a_hit <= hit_a_w;
         match_b_hit <= hit_b_w;
         span_a      <= span_a_w;
         span_b      <= span_b_w;
      end
   end

   a_bload_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TMP_OFF_B_LOAD && cfg_32bit) |=> $stable(load_b_q))
      else $error("timer B load changed while paired");
   a_bload_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TMP_OFF_B_LOAD && !cfg_32bit) |=> load_b_q == $past(pwdata[15:0]))
      else $error("timer B load write lost");
   a_rtc_match: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_rtc && count_a == {match_ah_q, match_al_q}) |=> rtc_match)
      else $error("RTC match missed");
   a_bmatch_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TMP_OFF_A_MATCH) |=> $stable(match_b_q))
      else $error("timer B match disturbed");
   a_rtc_low: assert property (@(posedge pclk) disable iff (!presetn)
      (count_a[15:0] != match_al_q) |=> !rtc_match)
      else $error("RTC match with low half unequal");
   a_span_calc: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> span_b == $past(load_b_q - match_b_q))
      else $error("edge span wrong");
   a_pre_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TMP_OFF_A_PRE) |=> ##1 pre_a == $past(pwdata[7:0], 2))
      else $error("prescale not stored");
   a_value_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == `TMP_OFF_A_VALUE && !cfg_32bit) |=> prdata[31:16] == 16'h0000)
      else $error("value high not zero in 16-bit");
   // Edge mode must hand back the captured stamp, not the live count
   a_value_stamp: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == `TMP_OFF_B_VALUE && mode_b == TMP_MODE_EDGE)
      |=> prdata[15:0] == $past(stamp_b))
      else $error("edge timestamp not returned");
   // Unpaired release must drop the match high half to zero
   a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_st_q == TMP_CFG_WAIT && !cfg_32bit) |=> match_ah_q == `TMP_HALF_ZERO)
      else $error("match high not cleared after release");
   c_b_load_write: cover property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `TMP_OFF_B_LOAD && !cfg_32bit);
   c_rtc_hit: cover property (@(posedge pclk) disable iff (!presetn) rtc_match);
   c_edge_read: cover property (@(posedge pclk) disable iff (!presetn)
      rd_en && paddr == `TMP_OFF_B_VALUE && mode_b == TMP_MODE_EDGE);
endmodule : tmp_regs
`default_nettype wire
